// [rtl/smt_pkg.sv]
`default_nettype none
package smt_pkg;
    // ****************************************
    // register byte addresses
    // ****************************************
    localparam logic [7:0] ADR_CONTROL  = 8'h00;
    localparam logic [7:0] ADR_STATUS   = 8'h04;
    localparam logic [7:0] ADR_CLOCK    = 8'h08;
    localparam logic [7:0] ADR_WIN1     = 8'h0c;
    localparam logic [7:0] ADR_WIN2     = 8'h10;
    localparam logic [7:0] ADR_SIG1     = 8'h14;
    localparam logic [7:0] ADR_SIG2     = 8'h18;
    localparam logic [7:0] ADR_CNT_LOW  = 8'h1c;
    localparam logic [7:0] ADR_CNT_HIGH = 8'h20;
    localparam logic [7:0] ADR_CNT_UPP  = 8'h24;

    // ****************************************
    // field positions and reset values
    // ****************************************
    localparam int GO_BIT      = 7;
    localparam int REPEAT_BIT  = 6;
    localparam int PRUP_BIT    = 7;
    localparam int WUP_BIT     = 6;
    localparam int CLR_BIT     = 5;
    localparam int INC_BIT     = 2;
    localparam int WIN_BIT     = 1;
    localparam int ACT_BIT     = 0;
    localparam logic [7:0] REG_RESET   = 8'h00;
    localparam logic [23:0] CNT_RESET  = 24'h000000;
    localparam logic [1:0] DIV4_LAST   = 2'h3;

    // ****************************************
    // operating modes and clock sources
    // ****************************************
    typedef enum logic [3:0] {
        MODE_TIMER      = 4'h0,
        MODE_GATED      = 4'h1,
        MODE_PERIOD     = 4'h2,
        MODE_HIGH_LOW   = 4'h3,
        MODE_WINDOWED   = 4'h4,
        MODE_GATED_WIN  = 4'h5,
        MODE_FLIGHT     = 4'h6,
        MODE_CAPTURE    = 4'h7,
        MODE_COUNTER    = 4'h8,
        MODE_GATED_CNT  = 4'h9,
        MODE_WIN_CNT    = 4'ha
    } mode_type;

    localparam logic [2:0] CLK_FOSC      = 3'h0;
    localparam logic [2:0] CLK_FOSC_DIV4 = 3'h1;
    localparam logic [2:0] CLK_RESERVED  = 3'h7;

    // ****************************************
    // source select maps per unit
    // ****************************************
    localparam logic [4:0]  WIN1_MATCH = 5'h12;
    localparam logic [4:0]  WIN2_MATCH = 5'h11;
    localparam logic [4:0]  SIG1_MATCH = 5'h0f;
    localparam logic [4:0]  SIG2_MATCH = 5'h0e;
    localparam logic [31:0] WIN1_RSVD  = 32'hff02_1800;
    localparam logic [31:0] WIN2_RSVD  = 32'hff04_1800;
    localparam logic [31:0] SIG1_RSVD  = 32'hffe0_4600;
    localparam logic [31:0] SIG2_RSVD  = 32'hffe0_8600;
endpackage
`default_nettype wire

// [rtl/smt_source_mux.sv]
`default_nettype none
module smt_source_mux #(
    parameter logic [31:0] RESERVED_MASK = 32'h0000_0000,
    parameter logic [4:0]  MATCH_CODE    = 5'h00
) (
    // inputs
    input  wire logic        i_pin,
    input  wire logic [31:0] i_sources,
    input  wire logic        i_other_match,
    input  wire logic [4:0]  i_select,
    // output
    output logic             o_selected
);
    wire reserved = RESERVED_MASK[i_select];
    wire is_pin   = (i_select == 5'h00);
    wire is_match = (i_select == MATCH_CODE);
    wire picked   = is_pin ? i_pin : (is_match ? i_other_match : i_sources[i_select]);

    // reserved codes give a quiet low input
    assign o_selected = !reserved && picked;
endmodule
`default_nettype wire

// [rtl/smt_control.sv]
// Added by the designer: the Wishbone interface to the registers and the placing of the registers.
`default_nettype none
// Function
// [RQ1] go enables counter incrementing and acquisition; clear stops both
// [RQ2] go bit is software read/write, hardware clearable, resets to zero
// [RQ3] repeat bit set selects repeated acquisition, clear selects single
// [RQ4] mode codes 0-3: timer, gated timer, period/duty, high/low time
// [RQ5] mode codes 4-7: windowed, gated windowed, time of flight, capture
// [RQ6] mode codes 8-10: counter, gated counter, windowed counter
// [RQ7] software must not program mode codes 11 to 15
// [RQ8] period update request copies count to captured period, then self-clears
// [RQ9] width update request copies count to captured width, then self-clears
// [RQ10] manual clear request zeroes the 24-bit counter, then self-clears
// [RQ11] increment status reads one while the counter is incrementing
// [RQ12] window status reads one while the measurement window is open
// [RQ13] acquire status reads one while an acquisition is in progress
// [RQ14] 3-bit clock field selects counter clock; code 7 reserved
// [RQ15] unit one window select map, code 18 is unit two match
// [RQ16] unit two window map, code 17 is unit one match, 18 reserved
// [RQ17] unit one signal select map, code 15 is unit two match
// [RQ18] unit two signal map, code 14 is unit one match, 15 reserved
// [RQ19] count low byte is read/write, bits 7-0, resets to zero
// [RQ20] unimplemented bits ignore writes and read back zero
// [RQ21] counter is 24 bits across low, high and upper byte registers
// [RQ22] single mode clears go at acquisition end; repeat keeps it set
module smt_control #(
    parameter int UNIT_INDEX = 1
) (
    // clock and reset
    input  wire logic        I_CLK,
    input  wire logic        I_RESET_N,
    // wishbone slave
    input  wire logic        I_WB_CYC,
    input  wire logic        I_WB_STB,
    input  wire logic        I_WB_WE,
    input  wire logic [7:0]  I_WB_ADR,
    input  wire logic [3:0]  I_WB_SEL,
    input  wire logic [31:0] I_WB_DAT,
    output logic      [31:0] O_WB_DAT,
    output logic             O_WB_ACK,
    // measured inputs
    input  wire logic        I_WINDOW_PIN,
    input  wire logic        I_SIGNAL_PIN,
    input  wire logic [31:0] I_WINDOW_SOURCES,
    input  wire logic [31:0] I_SIGNAL_SOURCES,
    input  wire logic        I_INSTANCE_ONE_MATCH,
    input  wire logic        I_INSTANCE_TWO_MATCH,
    input  wire logic [6:2]  I_CLOCK_SOURCES,
    // results
    output logic      [23:0] O_COUNT_VALUE,
    output logic      [23:0] O_CAPTURED_PERIOD,
    output logic      [23:0] O_CAPTURED_WIDTH,
    output logic      [1:0]  O_WINDOW_INPUT,
    output logic      [1:0]  O_SIGNAL_INPUT
);
    // ****************************************
    // acquisition states
    // ****************************************
    typedef enum logic [2:0] {
        ACQ_IDLE  = 3'b001,
        ACQ_ARMED = 3'b010,
        ACQ_RUN   = 3'b100
    } acq_type;

    acq_type     acq_q, acq_d;
    logic        go_q, repeat_q, prup_q, wup_q, clr_q;
    logic [3:0]  mode_q;
    logic [2:0]  clock_source_field_q;
    logic [4:0]  window_source_field_q [2];
    logic [4:0]  ssel_q [2];
    logic [23:0] count_q, period_q, width_q;
    logic [1:0]  div_q;
    logic        ack_q, clk_prev_q;
    logic [31:0] rdata_q;
    logic [1:0]  win_q, sig_q, win_prev_q, sig_prev_q;
    logic [1:0]  win_sel, sig_sel;

    // ****************************************
    // bus decode
    // ****************************************
    wire req      = I_WB_CYC && I_WB_STB;
    wire wr       = req && I_WB_WE && ack_q && I_WB_SEL[0];
    wire [7:0] wd = I_WB_DAT[7:0];
    wire wr_ctrl  = wr && (I_WB_ADR == smt_pkg::ADR_CONTROL);
    wire wr_stat  = wr && (I_WB_ADR == smt_pkg::ADR_STATUS);
    wire wr_clk   = wr && (I_WB_ADR == smt_pkg::ADR_CLOCK);
    wire wr_win1  = wr && (I_WB_ADR == smt_pkg::ADR_WIN1);
    wire wr_win2  = wr && (I_WB_ADR == smt_pkg::ADR_WIN2);
    wire wr_sig1  = wr && (I_WB_ADR == smt_pkg::ADR_SIG1);
    wire wr_sig2  = wr && (I_WB_ADR == smt_pkg::ADR_SIG2);
    wire wr_low   = wr && (I_WB_ADR == smt_pkg::ADR_CNT_LOW);
    wire wr_high  = wr && (I_WB_ADR == smt_pkg::ADR_CNT_HIGH);
    wire wr_upp   = wr && (I_WB_ADR == smt_pkg::ADR_CNT_UPP);
    wire wr_cnt   = wr_low || wr_high || wr_upp;

    // ****************************************
    // source selection per unit
    // ****************************************
    wire [1:0] other_match = {I_INSTANCE_ONE_MATCH, I_INSTANCE_TWO_MATCH};
    localparam logic [31:0] WIN_RSVD [2]  = '{smt_pkg::WIN1_RSVD, smt_pkg::WIN2_RSVD};
    localparam logic [31:0] SIG_RSVD [2]  = '{smt_pkg::SIG1_RSVD, smt_pkg::SIG2_RSVD};
    localparam logic [4:0]  WIN_MATCH [2] = '{smt_pkg::WIN1_MATCH, smt_pkg::WIN2_MATCH};
    localparam logic [4:0]  SIG_MATCH [2] = '{smt_pkg::SIG1_MATCH, smt_pkg::SIG2_MATCH};

    genvar u;
    generate
        for (u = 0; u < 2; u++) begin : g_unit
            smt_source_mux #(
                .RESERVED_MASK (WIN_RSVD[u]),
                .MATCH_CODE    (WIN_MATCH[u])
            ) u_win (
                .i_pin         (I_WINDOW_PIN),
                .i_sources     (I_WINDOW_SOURCES),
                .i_other_match (other_match[u]),
                .i_select      (window_source_field_q[u]),
                .o_selected    (win_sel[u])
            ); // RQ15 RQ16
            smt_source_mux #(
                .RESERVED_MASK (SIG_RSVD[u]),
                .MATCH_CODE    (SIG_MATCH[u])
            ) u_sig (
                .i_pin         (I_SIGNAL_PIN),
                .i_sources     (I_SIGNAL_SOURCES),
                .i_other_match (other_match[u]),
                .i_select      (ssel_q[u]),
                .o_selected    (sig_sel[u])
            ); // RQ17 RQ18
        end
    endgenerate

    // selected inputs are flopped so edges are seen one cycle late
    always_ff @(posedge I_CLK) begin
        if (!I_RESET_N) begin
            win_q      <= 2'h0;
            sig_q      <= 2'h0;
            win_prev_q <= 2'h0;
            sig_prev_q <= 2'h0;
        end else begin
            win_q      <= win_sel;
            sig_q      <= sig_sel;
            win_prev_q <= win_q;
            sig_prev_q <= sig_q;
        end
    end

    localparam int ME = UNIT_INDEX - 1;
    wire win      = win_q[ME];
    wire sig      = sig_q[ME];
    wire win_rise = win && !win_prev_q[ME];
    wire win_fall = !win && win_prev_q[ME];
    wire sig_rise = sig && !sig_prev_q[ME];

    // ****************************************
    // clock source and divider
    // ****************************************
    wire div_en      = (div_q == smt_pkg::DIV4_LAST);
    wire [7:0] cvec  = {1'b0, I_CLOCK_SOURCES, 2'h0};
    wire clk_level   = cvec[clock_source_field_q];
    wire is_fosc     = (clock_source_field_q == smt_pkg::CLK_FOSC);
    wire is_div4     = (clock_source_field_q == smt_pkg::CLK_FOSC_DIV4);
    wire clk_edge    = clk_level && !clk_prev_q;
    wire tick        = is_fosc || (is_div4 ? div_en : clk_edge); // RQ14

    always_ff @(posedge I_CLK) begin
        if (!I_RESET_N) begin
            div_q      <= 2'h0;
            clk_prev_q <= 1'b0;
        end else begin
            div_q      <= div_q + 2'h1;
            clk_prev_q <= clk_level;
        end
    end

    // ****************************************
    // mode decode
    // ****************************************
    wire m_timer  = (mode_q == smt_pkg::MODE_TIMER);
    wire m_gated  = (mode_q == smt_pkg::MODE_GATED);
    wire m_period = (mode_q == smt_pkg::MODE_PERIOD) || (mode_q == smt_pkg::MODE_HIGH_LOW); // RQ4
    wire m_win    = (mode_q == smt_pkg::MODE_WINDOWED) || (mode_q == smt_pkg::MODE_GATED_WIN);
    wire m_gwin   = (mode_q == smt_pkg::MODE_GATED_WIN);
    wire m_flight = (mode_q == smt_pkg::MODE_FLIGHT);
    wire m_capt   = (mode_q == smt_pkg::MODE_CAPTURE); // RQ5
    wire m_cnt    = (mode_q == smt_pkg::MODE_COUNTER);
    wire m_gcnt   = (mode_q == smt_pkg::MODE_GATED_CNT);
    wire m_wcnt   = (mode_q == smt_pkg::MODE_WIN_CNT); // RQ6
    wire counting = m_cnt || m_gcnt || m_wcnt;
    // reserved codes hold the counter still rather than guess a mode
    wire m_rsvd   = (mode_q > smt_pkg::MODE_WIN_CNT); // RQ7

    wire needs_start = m_period || m_win || m_flight || m_wcnt;
    wire start_evt   = m_period ? sig_rise : win_rise;
    wire done_evt    = (m_period || m_flight) ? sig_rise :
                       (m_win || m_wcnt || m_capt) ? win_rise :
                       (m_cnt || m_gcnt) ? win_fall : 1'b0;

    // ****************************************
    // acquisition sequence
    // ****************************************
    wire run      = (acq_q == ACQ_RUN);
    wire finish   = run && go_q && done_evt && !repeat_q; // RQ3
    wire gate     = m_gated ? sig : (m_gwin ? sig : (m_gcnt ? win : 1'b1));
    wire inc_stat = go_q && run && gate && !m_rsvd; // RQ1 RQ11
    wire step     = counting ? sig_rise : tick;
    wire inc      = inc_stat && step;

    always_comb begin
        acq_d = acq_q;
        unique case (acq_q)
            ACQ_IDLE: begin
                if (go_q && !m_rsvd) begin
                    acq_d = needs_start ? ACQ_ARMED : ACQ_RUN;
                end
            end
            ACQ_ARMED: begin
                if (!go_q) begin
                    acq_d = ACQ_IDLE;
                end else if (start_evt) begin
                    acq_d = ACQ_RUN;
                end
            end
            ACQ_RUN: begin
                if (!go_q || finish) begin
                    acq_d = ACQ_IDLE;
                end
            end
            default: acq_d = ACQ_IDLE;
        endcase
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RESET_N) begin
            acq_q <= ACQ_IDLE;
        end else begin
            acq_q <= acq_d;
        end
    end

    // ****************************************
    // control and select registers
    // ****************************************
    always_ff @(posedge I_CLK) begin
        if (!I_RESET_N) begin
            go_q     <= smt_pkg::REG_RESET[smt_pkg::GO_BIT];
            repeat_q <= smt_pkg::REG_RESET[smt_pkg::REPEAT_BIT];
            mode_q   <= smt_pkg::REG_RESET[3:0];
            clock_source_field_q   <= smt_pkg::REG_RESET[2:0];
            window_source_field_q   <= '{smt_pkg::REG_RESET[4:0], smt_pkg::REG_RESET[4:0]};
            ssel_q   <= '{smt_pkg::REG_RESET[4:0], smt_pkg::REG_RESET[4:0]};
        end else begin
            // a software write wins over the hardware clear
            if (wr_ctrl) begin
                go_q     <= wd[smt_pkg::GO_BIT]; // RQ2
                repeat_q <= wd[smt_pkg::REPEAT_BIT];
                mode_q   <= wd[3:0];
            end else if (finish) begin
                go_q <= 1'b0; // RQ22
            end
            if (wr_clk)  clock_source_field_q    <= wd[2:0]; // RQ20
            if (wr_win1) window_source_field_q[0] <= wd[4:0];
            if (wr_win2) window_source_field_q[1] <= wd[4:0];
            if (wr_sig1) ssel_q[0] <= wd[4:0];
            if (wr_sig2) ssel_q[1] <= wd[4:0];
        end
    end

    // ****************************************
    // update requests and counter
    // ****************************************
    // each request is served at the edge after it is seen, so it stands one cycle
    always_ff @(posedge I_CLK) begin
        if (!I_RESET_N) begin
            prup_q   <= 1'b0;
            wup_q    <= 1'b0;
            clr_q    <= 1'b0;
            period_q <= smt_pkg::CNT_RESET;
            width_q  <= smt_pkg::CNT_RESET;
        end else begin
            prup_q <= wr_stat && wd[smt_pkg::PRUP_BIT]; // RQ8
            wup_q  <= wr_stat && wd[smt_pkg::WUP_BIT]; // RQ9
            clr_q  <= wr_stat && wd[smt_pkg::CLR_BIT]; // RQ10
            if (prup_q) period_q <= count_q; // RQ8
            if (wup_q)  width_q  <= count_q; // RQ9
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RESET_N) begin
            count_q <= smt_pkg::CNT_RESET; // RQ19
        end else if (clr_q) begin
            count_q <= smt_pkg::CNT_RESET; // RQ10
        end else if (wr_cnt) begin
            if (wr_low)  count_q[7:0]   <= wd; // RQ19
            if (wr_high) count_q[15:8]  <= wd;
            if (wr_upp)  count_q[23:16] <= wd; // RQ21
        end else if (inc) begin
            count_q <= count_q + 24'h000001; // RQ1
        end
    end

    // ****************************************
    // read mux and acknowledge
    // ****************************************
    wire [7:0] rd_ctrl = {go_q, repeat_q, 2'h0, mode_q}; // RQ20
    wire [7:0] rd_stat = {prup_q, wup_q, clr_q, 2'h0, inc_stat, win, run}; // RQ11 RQ12 RQ13
    wire [7:0] rd_byte =
        (I_WB_ADR == smt_pkg::ADR_CONTROL)  ? rd_ctrl :
        (I_WB_ADR == smt_pkg::ADR_STATUS)   ? rd_stat :
        (I_WB_ADR == smt_pkg::ADR_CLOCK)    ? {5'h00, clock_source_field_q} :
        (I_WB_ADR == smt_pkg::ADR_WIN1)     ? {3'h0, window_source_field_q[0]} :
        (I_WB_ADR == smt_pkg::ADR_WIN2)     ? {3'h0, window_source_field_q[1]} :
        (I_WB_ADR == smt_pkg::ADR_SIG1)     ? {3'h0, ssel_q[0]} :
        (I_WB_ADR == smt_pkg::ADR_SIG2)     ? {3'h0, ssel_q[1]} :
        (I_WB_ADR == smt_pkg::ADR_CNT_LOW)  ? count_q[7:0] :
        (I_WB_ADR == smt_pkg::ADR_CNT_HIGH) ? count_q[15:8] :
        (I_WB_ADR == smt_pkg::ADR_CNT_UPP)  ? count_q[23:16] : 8'h00;

    // one wait state; unmapped addresses still ack and read zero
    always_ff @(posedge I_CLK) begin
        if (!I_RESET_N) begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q <= req && !ack_q;
            if (req && !ack_q) rdata_q <= {24'h000000, rd_byte};
        end
    end

    assign O_WB_ACK          = ack_q;
    assign O_WB_DAT          = rdata_q;
    assign O_COUNT_VALUE     = count_q;
    assign O_CAPTURED_PERIOD = period_q;
    assign O_CAPTURED_WIDTH  = width_q;
    assign O_WINDOW_INPUT    = win_q;
    assign O_SIGNAL_INPUT    = sig_q;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RESET_N);

    go_stop_a: assert property (!go_q && !clr_q && !wr_cnt |=> $stable(count_q)) // RQ1
        else $error("counter moved while go clear");
    go_hwclr_a: assert property (finish && !wr_ctrl |=> !go_q && acq_q == ACQ_IDLE) // RQ22
        else $error("single acquisition left go set");
    repeat_hold_a: assert property (go_q && repeat_q && !wr_ctrl |=> go_q) // RQ3
        else $error("repeat mode lost go");
    rsvd_mode_a: assert property (m_rsvd && !clr_q && !wr_cnt |=> $stable(count_q)) // RQ7
        else $error("reserved mode incremented");
    prup_done_a: assert property (prup_q && !wr_stat |=> period_q == $past(count_q) && !prup_q) // RQ8
        else $error("period update not done");
    wup_done_a: assert property (wup_q && !wr_stat |=> width_q == $past(count_q) && !wup_q) // RQ9
        else $error("width update not done");
    clr_done_a: assert property (wr_stat && wd[smt_pkg::CLR_BIT] |=> ##1 count_q == 24'h000000) // RQ10
        else $error("manual clear missed");
    inc_step_a: assert property (inc && !clr_q && !wr_cnt |=> count_q == $past(count_q) + 24'h000001) // RQ11
        else $error("increment lost");
    acq_status_a: assert property (go_q && !needs_start && acq_q == ACQ_IDLE && !m_rsvd |=> run) // RQ13
        else $error("acquisition did not start");
    unimpl_zero_a: assert property (O_WB_ACK |-> O_WB_DAT[31:8] == 24'h000000) // RQ20
        else $error("upper read bits not zero");
    ack_pulse_a: assert property (O_WB_ACK |=> !O_WB_ACK)
        else $error("ack held two cycles");

    single_done_c: cover property (finish);
    repeat_run_c: cover property (run && done_evt && repeat_q);
    manual_clr_c: cover property (clr_q && count_q != 24'h000000);
    count_write_c: cover property (wr_low ##1 inc);
endmodule
`default_nettype wire

// [tb/smt_sources_model.sv]
`default_nettype none
module smt_sources_model (
    // control from bench
    input  wire logic        i_clk,
    input  wire logic        i_level,
    input  wire logic [4:0]  i_code,
    // driven lines
    output logic             o_win_pin,
    output logic             o_sig_pin,
    output logic      [31:0] o_win_src,
    output logic      [31:0] o_sig_src,
    output logic             o_one_match,
    output logic             o_two_match,
    output logic      [6:2]  o_clk_src
);
    timeunit 1ns;
    timeprecision 1ns;
    // ********
    // sources
    // ********
    logic [1:0] div_q = 2'h0;
    // only the addressed line carries the level, so a wrong pick reads low
    assign o_win_pin   = i_level & (i_code == 5'h00);
    assign o_sig_pin   = o_win_pin;
    // pin and match codes stay low on the source buses, so only the right path reads high
    assign o_win_src   = i_level ? ((32'h1 << i_code) & 32'hfff9_fffe) : 32'h0;
    assign o_sig_src   = i_level ? ((32'h1 << i_code) & 32'hffff_3ffe) : 32'h0;
    assign o_one_match = i_level & (i_code == 5'h11 || i_code == 5'h0e);
    assign o_two_match = i_level & (i_code == 5'h12 || i_code == 5'h0f);
    assign o_clk_src   = {5{div_q[1]}};
    always_ff @(posedge i_clk) begin
        div_q <= div_q + 2'h1;
    end
endmodule
`default_nettype wire

// [tb/signal_measure_timer_control_tb_top.sv]
`default_nettype none
module signal_measure_timer_control_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    // ********
    // signals
    // ********
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        cyc = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [3:0]  sel = 4'h0;
    logic [31:0] rdat;
    logic        ack;
    logic        lvl = 1'b0;
    logic [4:0]  code = 5'h00;
    logic        wpin;
    logic        spin;
    logic [31:0] wsrc;
    logic [31:0] ssrc;
    logic        m1;
    logic        m2;
    logic [6:2]  cksrc;
    logic [23:0] cnt;
    logic [23:0] per;
    logic [23:0] wid;
    logic [1:0]  win_in;
    logic [1:0]  sig_in;
    logic [7:0]  r;
    int          error_cnt = 0;
    int          total_checks = 0;
    int          cycles = 0;
    logic [31:0] rsvd [4] = '{32'hff021800, 32'hff041800, 32'hffe04600, 32'hffe08600};
    wire logic [3:0] picked = {sig_in, win_in};

    smt_control i_dut (.I_CLK(clk), .I_RESET_N(rst_n), .I_WB_CYC(cyc), .I_WB_STB(cyc),
        .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(rdat),
        .O_WB_ACK(ack), .I_WINDOW_PIN(wpin), .I_SIGNAL_PIN(spin), .I_WINDOW_SOURCES(wsrc),
        .I_SIGNAL_SOURCES(ssrc), .I_INSTANCE_ONE_MATCH(m1), .I_INSTANCE_TWO_MATCH(m2),
        .I_CLOCK_SOURCES(cksrc), .O_COUNT_VALUE(cnt), .O_CAPTURED_PERIOD(per),
        .O_CAPTURED_WIDTH(wid), .O_WINDOW_INPUT(win_in), .O_SIGNAL_INPUT(sig_in));
    smt_sources_model i_src (.i_clk(clk), .i_level(lvl), .i_code(code), .o_win_pin(wpin),
        .o_sig_pin(spin), .o_win_src(wsrc), .o_sig_src(ssrc), .o_one_match(m1),
        .o_two_match(m2), .o_clk_src(cksrc));

    always #50 clk = ~clk;

    // a hung handshake ends here as a mismatch
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            error_cnt++;
            final_report();
        end
    end
    // ********
    // tasks
    // ********
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic s0);
        @(posedge clk);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        sel <= {3'h0, s0};
        do @(posedge clk); while (ack !== 1'b1);
        r = rdat[7:0];
        cyc <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d, 1'b1);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00, 1'b1);
        cmp({16'h0, r}, {16'h0, e});
    endtask
    task automatic done(input string name);
        $display("test %s done", name);
    endtask
    // ********
    // sequence
    // ********
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        for (int a = 0; a <= 'h40; a += 4)
            rdc(8'(a), 8'h00);
        done("reset");
        for (int m = 0; m < 11; m++) begin
            wr(smt_pkg::ADR_CONTROL, {1'b0, m[0], 2'b11, 4'(m)});
            rdc(smt_pkg::ADR_CONTROL, {1'b0, m[0], 2'b00, 4'(m)});
        end
        wr(smt_pkg::ADR_CLOCK, 8'hff);
        rdc(smt_pkg::ADR_CLOCK, 8'h07);
        wr(smt_pkg::ADR_STATUS, 8'h1f);
        rdc(smt_pkg::ADR_STATUS, 8'h00);
        bus(1'b1, smt_pkg::ADR_CNT_LOW, 8'h77, 1'b0);
        rdc(smt_pkg::ADR_CNT_LOW, 8'h00);
        wr(smt_pkg::ADR_CNT_LOW, 8'h5a);
        wr(smt_pkg::ADR_CNT_HIGH, 8'h3c);
        wr(smt_pkg::ADR_CNT_UPP, 8'h81);
        rdc(smt_pkg::ADR_CNT_LOW, 8'h5a);
        cmp(cnt, 24'h813c5a);
        wr(smt_pkg::ADR_STATUS, 8'h80);
        rdc(smt_pkg::ADR_STATUS, 8'h00);
        cmp(per, 24'h813c5a);
        wr(smt_pkg::ADR_STATUS, 8'h40);
        repeat (2) @(posedge clk);
        cmp(wid, 24'h813c5a);
        wr(smt_pkg::ADR_STATUS, 8'h20);
        repeat (2) @(posedge clk);
        cmp(cnt, 24'h000000);
        done("registers");
        // all 32 codes of all four selects, high then low
        for (int s = 0; s < 4; s++) begin
            for (int c = 0; c < 32; c++) begin
                code <= 5'(c);
                lvl <= 1'b1;
                wr(8'(12 + 4 * s), 8'(c));
                repeat (3) @(posedge clk);
                cmp({23'h0, picked[s]}, {23'h0, ~rsvd[s][c]});
                lvl <= 1'b0;
                repeat (3) @(posedge clk);
                cmp({23'h0, picked[s]}, 24'h0);
            end
        end
        done("sources");
        for (int c = 0; c < 8; c++) begin
            wr(smt_pkg::ADR_CLOCK, 8'(c));
            wr(smt_pkg::ADR_STATUS, 8'h20);
            wr(smt_pkg::ADR_CONTROL, 8'h80);
            rdc(smt_pkg::ADR_STATUS, 8'h05);
            repeat (20) @(posedge clk);
            wr(smt_pkg::ADR_CONTROL, 8'h00);
            rdc(smt_pkg::ADR_STATUS, 8'h00);
            cmp({23'h0, cnt != 24'h0}, {23'h0, c != 7});
        end
        done("clocks");
        wr(smt_pkg::ADR_CLOCK, 8'h00);
        wr(smt_pkg::ADR_WIN1, 8'h00);
        code <= 5'h00;
        for (int k = 0; k < 2; k++) begin
            wr(smt_pkg::ADR_CONTROL, {1'b1, k[0], 6'h04});
            lvl <= 1'b1;
            repeat (4) @(posedge clk);
            rdc(smt_pkg::ADR_STATUS, 8'h07);
            lvl <= 1'b0;
            repeat (4) @(posedge clk);
            lvl <= 1'b1;
            repeat (4) @(posedge clk);
            lvl <= 1'b0;
            rdc(smt_pkg::ADR_CONTROL, {k[0], k[0], 6'h04});
            wr(smt_pkg::ADR_CONTROL, 8'h00);
        end
        done("acquisition");
        // counter mode in repeat: each signal rise is one count
        wr(smt_pkg::ADR_SIG1, 8'h00);
        wr(smt_pkg::ADR_STATUS, 8'h20);
        wr(smt_pkg::ADR_CONTROL, 8'hc8);
        repeat (3) begin
            lvl <= 1'b1;
            repeat (4) @(posedge clk);
            lvl <= 1'b0;
            repeat (4) @(posedge clk);
        end
        cmp(cnt, 24'h000003);
        wr(smt_pkg::ADR_CONTROL, 8'h00);
        done("counter");
        final_report();
    end
endmodule
`default_nettype wire
